// *** otcc_clock_ctrl.sv ***
// Top: internal oscillator model, trim and clock pin direction control
`timescale 1ns/10ps
// Functional notes
// RULE1 - Trim field is five-bit two's complement
// RULE2 - Zero nominal; signed code raises or lowers
// RULE3 - Select low: oscillator stopped, pin input
// RULE4 - Select high, enable 0: run, pin released
// RULE5 - Select high, enable 1: drive clock out
// RULE6 - Trim sits in control bits 12..8
// RULE7 - Output enable is control bit 0
module otcc_clock_ctrl
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Oscillator control word load
  input  wire logic [15:0] oscCtrlData,
  input  wire logic        oscCtrlWrite,
  // Clock source select pin
  input  wire logic        clock_source_select_pin,
  // Clock pin, split into three signals
  input  wire logic        clockPinIn,
  output logic             clockPinOut,
  output logic             clockPinOe_n,
  // Status and chosen core clock
  output logic [15:0]      oscCtrl,
  output logic             internalOscRunning,
  output logic             coreClock,
  output otcc_pkg::otcc_mode_t pinMode
);

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic [2:0]  selSync;
  logic [2:0]  pinSync;
  logic        selStable;
  logic        extClock;
  logic [10:0] factorPermille;
  logic [23:0] phaseAcc;
  logic        oscLevel;

  wire  [4:0]  trimCode;
  wire         clockOutEnable;
  wire         selNext;
  wire         oscRun;
  wire  [23:0] phaseStep;
  wire  [34:0] stepProduct;
  wire  [15:0] next_oscCtrl;
  wire         next_extClock;
  wire  [23:0] next_phaseAcc;
  wire         next_oscLevel;
  wire         next_clockPinOe_n;
  wire         next_coreClock;
  otcc_pkg::otcc_mode_t next_pinMode;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Stages two and three apart means a change still settling;
  // holding the old level keeps a metastable sample out
  function automatic logic agreeFilter(input logic [2:0] stages,
                                       input logic       held);
    if (stages[1] == stages[2])
      agreeFilter = stages[2];
    else
      agreeFilter = held;
  endfunction

  // Pin driver is on only in the output mode
  function automatic logic driverOn(input otcc_pkg::otcc_mode_t mode);
    driverOn = (mode == otcc_pkg::OTCC_INT_OUT);
  endfunction

  // ---------------------------------------------------------------
  // Control word fields
  // ---------------------------------------------------------------
  // Trim is signed; the lookup deals with the sign
  assign trimCode =
    oscCtrl[otcc_pkg::TRIM_MSB:otcc_pkg::TRIM_LSB]; // RULE6 RULE1
  assign clockOutEnable = oscCtrl[otcc_pkg::CKOUT_EN_BIT]; // RULE7

  // Unused and reserved bits held at zero, so reads show no noise
  assign next_oscCtrl = oscCtrlData & otcc_pkg::CTRL_KEEP; // RULE6 RULE7

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      oscCtrl <= otcc_pkg::CTRL_RESET;
    else if (oscCtrlWrite)
      oscCtrl <= next_oscCtrl;
  end

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------
  // Change taken only once stages two and three agree
  assign selNext       = agreeFilter(selSync, selStable);
  assign next_extClock = agreeFilter(pinSync, extClock);

  // Select pin
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      selSync   <= 3'h0;
      selStable <= 1'b0;
    end
    else
    begin
      selSync   <= {selSync[1:0], clock_source_select_pin};
      selStable <= selNext;
    end
  end

  // Clock pin; only used while the pin is an input
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinSync  <= 3'h0;
      extClock <= 1'b0;
    end
    else
    begin
      pinSync  <= {pinSync[1:0], clockPinIn};
      extClock <= next_extClock;
    end
  end

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  // Select pin wins over the enable bit: with it low the pin is an
  // input, whatever the control word asks for
  assign oscRun = selStable; // RULE3 RULE4 RULE5
  assign next_pinMode = !selStable     ? otcc_pkg::OTCC_EXT_IN :  // RULE3
                        clockOutEnable ? otcc_pkg::OTCC_INT_OUT : // RULE5
                                         otcc_pkg::OTCC_INT_HIZ;  // RULE4

  // ---------------------------------------------------------------
  // Internal oscillator model
  // ---------------------------------------------------------------
  // Factor is registered in the lookup, so a new trim takes hold
  // one cycle after the write
  otcc_trim_rom u_trim_rom
  (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .trimCode       (trimCode),
    .factorPermille (factorPermille)
  );

  // Step scales with trim factor; zero code keeps nominal rate
  assign stepProduct = otcc_pkg::PHASE_NOM_STEP * factorPermille; // RULE2
  assign phaseStep   = 24'(stepProduct / otcc_pkg::PERMILLE_DIV); // RULE2

  // Stopped oscillator restarts from phase zero, level low
  assign next_phaseAcc = oscRun ? 24'(phaseAcc + phaseStep)
                                : otcc_pkg::PHASE_RESET; // RULE3
  assign next_oscLevel = oscRun ? phaseAcc[23] : 1'b0; // RULE3

  // Accumulator is a model only; trim resolution limited by step width
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phaseAcc <= otcc_pkg::PHASE_RESET;
      oscLevel <= 1'b0;
    end
    else
    begin
      phaseAcc <= next_phaseAcc;
      oscLevel <= next_oscLevel;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign next_clockPinOe_n = !driverOn(next_pinMode); // RULE4 RULE5
  assign next_coreClock    = oscRun ? oscLevel : extClock; // RULE3

  // Level and enable launched on one edge, so the pin never glitches
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clockPinOut  <= 1'b0;
      clockPinOe_n <= 1'b1;
    end
    else
    begin
      clockPinOut  <= oscLevel;
      clockPinOe_n <= next_clockPinOe_n;
    end
  end

  // Status
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinMode            <= otcc_pkg::OTCC_EXT_IN;
      internalOscRunning <= 1'b0;
    end
    else
    begin
      pinMode            <= next_pinMode;
      internalOscRunning <= oscRun;
    end
  end

  // Core clock follows the oscillator, or the synced pin when stopped
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      coreClock <= 1'b0;
    else
      coreClock <= next_coreClock;
  end

endmodule

// *** otcc_clock_ctrl_bench.sv ***
// Bench: control word, pin modes and trimmed oscillator period
`timescale 1ns/10ps
module otcc_clock_ctrl_bench;
  logic sys_clk = 1'b0, reset_n = 1'b0, oscCtrlWrite = 1'b0, sel = 1'b0;
  logic [15:0] oscCtrlData = 16'h0000, oscCtrl, d;
  logic clockPinOut, clockPinOe_n, internalOscRunning, coreClock;
  logic extClk, pin, p;
  otcc_pkg::otcc_mode_t pinMode;
  int errCount = 0, checkCount = 0, seed = 32'h432b, i, n, e;
  logic [4:0] codes [5] = '{5'h0f, 5'h01, 5'h00, 5'h1f, 5'h10};
  always #5 sys_clk = !sys_clk;
  assign pin = !clockPinOe_n ? clockPinOut : extClk;
  otcc_ext_clock ext (.sys_clk(sys_clk), .enable(!sel), .clkOut(extClk));
  otcc_clock_ctrl uut (.sys_clk(sys_clk), .reset_n(reset_n),
    .oscCtrlData(oscCtrlData), .oscCtrlWrite(oscCtrlWrite),
    .clock_source_select_pin(sel), .clockPinIn(pin),
    .clockPinOut(clockPinOut), .clockPinOe_n(clockPinOe_n),
    .oscCtrl(oscCtrl), .internalOscRunning(internalOscRunning),
    .coreClock(coreClock), .pinMode(pinMode));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function int pm(input logic [4:0] c);
    case (c)
      5'h0f: pm = 437;
      5'h01: pm = 14;
      5'h1f: pm = -34;
      5'h10: pm = -430;
      default: pm = 0;
    endcase
  endfunction
  task conclude;
    if (errCount == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic ok, input string msg);
    checkCount++;
    if (ok !== 1'b1)
    begin
      errCount++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task wr(input logic [15:0] v);
    @(negedge sys_clk) oscCtrlData = v;
    oscCtrlWrite = 1'b1;
    @(negedge sys_clk) oscCtrlWrite = 1'b0;
  endtask
  // Cycles between the second and third rising edge of the pin output
  task per(input int edges, output int m);
    int j, r;
    p = clockPinOut;
    r = 0;
    m = 0;
    for (j = 0; j < 1000 && r < edges; j++)
    begin
      @(negedge sys_clk);
      if (r > 1) m++;
      if (clockPinOut === 1'b1 && p === 1'b0) r++;
      p = clockPinOut;
    end
    if (r < edges)
    begin
      errCount++;
      $display("MISMATCH %0t no clock edges on pin", $time);
      conclude;
    end
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    chk(oscCtrl === 16'h0000 && clockPinOe_n === 1'b1, "reset");
    for (i = 0; i < 16; i++)
    begin
      d = $random(seed);
      wr(d);
      chk(oscCtrl === (d & 16'h1f01), "ctrl load");
    end
    wr(16'h0001);
    n = 0;
    p = coreClock;
    for (i = 0; i < 200; i++)
    begin
      @(negedge sys_clk);
      if (coreClock !== p) n++;
      p = coreClock;
    end
    chk(n >= 38 && n <= 42 && clockPinOe_n === 1'b1, "ext clock");
    chk(internalOscRunning === 1'b0, "osc halted");
    sel = 1'b1;
    wr(16'h0000);
    repeat (8) @(negedge sys_clk);
    chk(internalOscRunning === 1'b1 && clockPinOe_n === 1'b1, "hiz");
    for (i = 0; i < 5; i++)
    begin
      wr({3'h0, codes[i], 8'h01});
      per(3, n);
      e = 128000 / (1000 + pm(codes[i]));
      chk(n <= e + 2 && n + 2 >= e && clockPinOe_n === 1'b0,
          "trim period");
    end
    // Select low again with enable still set: must stop and release
    sel = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk({internalOscRunning, clockPinOe_n, clockPinOut} === 3'h2,
        "stop");
    conclude;
  end
endmodule
bind otcc_clock_ctrl otcc_clock_ctrl_props props (
  .sys_clk(sys_clk), .reset_n(reset_n), .oscCtrlData(oscCtrlData),
  .oscCtrlWrite(oscCtrlWrite),
  .clock_source_select_pin(clock_source_select_pin),
  .clockPinOut(clockPinOut), .clockPinOe_n(clockPinOe_n),
  .oscCtrl(oscCtrl), .internalOscRunning(internalOscRunning),
  .pinMode(pinMode));

// *** otcc_clock_ctrl_props.sv ***
// Checker: pin direction and control word relations at the top ports
`timescale 1ns/10ps
module otcc_clock_ctrl_props
(
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  // Inputs seen
  input wire logic [15:0]          oscCtrlData,
  input wire logic                 oscCtrlWrite,
  input wire logic                 clock_source_select_pin,
  // Outputs seen
  input wire logic                 clockPinOut,
  input wire logic                 clockPinOe_n,
  input wire logic [15:0]          oscCtrl,
  input wire logic                 internalOscRunning,
  input wire otcc_pkg::otcc_mode_t pinMode
);
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_ctrl_load: assert property (oscCtrlWrite |=>
    oscCtrl == ($past(oscCtrlData) & 16'h1f01)) else $error("bad load");
  chk_unused_zero: assert property ((oscCtrl & 16'he0fe) == 16'h0000)
    else $error("unused bits set");
  chk_ext_halt: assert property (pinMode == otcc_pkg::OTCC_EXT_IN
    |-> !internalOscRunning && clockPinOe_n) else $error("ext mode");
  chk_hiz_run: assert property (pinMode == otcc_pkg::OTCC_INT_HIZ
    |-> internalOscRunning && clockPinOe_n) else $error("hiz mode");
  chk_out_drive: assert property (!clockPinOe_n
    |-> pinMode == otcc_pkg::OTCC_INT_OUT && internalOscRunning)
    else $error("drive mode");
  chk_sel_low: assert property (!clock_source_select_pin[*6]
    |-> pinMode == otcc_pkg::OTCC_EXT_IN) else $error("select low");
  chk_en_out: assert property (
    (clock_source_select_pin && oscCtrl[0])[*6] |-> !clockPinOe_n)
    else $error("not driving");
  chk_stop_low: assert property (
    !internalOscRunning && !$past(internalOscRunning) |-> !clockPinOut)
    else $error("stopped pin toggles");
endmodule

// *** otcc_ext_clock.sv ***
// Partner: external clock source on the clock pin
`timescale 1ns/10ps
module otcc_ext_clock
#(
  parameter int HALF = 5
)
(
  // Control
  input wire logic sys_clk,
  input wire logic enable,
  // Pin drive
  output logic     clkOut
);
  int cnt = 0;
  initial clkOut = 1'b0;
  // Released: toggles each cycle so a stale level never passes
  always @(negedge sys_clk)
  begin
    cnt = (cnt + 1) % HALF;
    if (!enable || cnt == 0) clkOut <= !clkOut;
  end
endmodule

// *** otcc_pkg.sv ***
// Package: oscillator trim and clock pin control constants
package otcc_pkg;

  // ---------------------------------------------------------------
  // Oscillator control word layout
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_WIDTH    = 16;
  localparam int unsigned TRIM_MSB      = 12;
  localparam int unsigned TRIM_LSB      = 8;
  localparam int unsigned TRIM_WIDTH    = 5;
  localparam int unsigned CKOUT_EN_BIT  = 0;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_KEEP     = 16'h1f01;
  localparam logic [4:0]  TRIM_RESET    = 5'h00;
  localparam logic [4:0]  TRIM_MAX_CODE = 5'h0f;
  localparam logic [4:0]  TRIM_MIN_CODE = 5'h10;

  // ---------------------------------------------------------------
  // Oscillator model timing
  // ---------------------------------------------------------------
  localparam int unsigned NOM_HALF_TIME_NS = 40;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  // Reference half period rounded up to whole system cycles
  localparam int unsigned NOM_HALF_CYCLES  =
    (NOM_HALF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PHASE_WIDTH      = 24;
  localparam logic [23:0] PHASE_NOM_STEP   = 24'h020000;
  localparam logic [23:0] PHASE_RESET      = 24'h000000;
  localparam logic [10:0] FACTOR_NOMINAL   = 11'h3e8;
  localparam logic [34:0] PERMILLE_DIV     = 35'h000003e8;

  // Pin source modes
  typedef enum logic [1:0] {
    OTCC_EXT_IN,
    OTCC_INT_HIZ,
    OTCC_INT_OUT
  } otcc_mode_t;

endpackage

// *** otcc_trim_rom.sv ***
// Trim lookup: signed trim code to per-mille frequency factor
`timescale 1ns/10ps
module otcc_trim_rom
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Lookup
  input  wire logic [4:0]  trimCode,
  output logic      [10:0] factorPermille
);

  // ---------------------------------------------------------------
  // Table: per-mille factor, 1000 plus ten times the percent change
  // ---------------------------------------------------------------
  function automatic logic [10:0] trimFactor(input logic [4:0] code);
    case (code)
      5'h0f: trimFactor = 11'h59d;
      5'h0e: trimFactor = 11'h58e;
      5'h0d: trimFactor = 11'h579;
      5'h0c: trimFactor = 11'h568;
      5'h0b: trimFactor = 11'h548;
      5'h0a: trimFactor = 11'h530;
      5'h09: trimFactor = 11'h508;
      5'h08: trimFactor = 11'h4e7;
      5'h07: trimFactor = 11'h499;
      5'h06: trimFactor = 11'h475;
      5'h05: trimFactor = 11'h44c;
      5'h04: trimFactor = 11'h43c;
      5'h03: trimFactor = 11'h41e;
      5'h02: trimFactor = 11'h40c;
      5'h01: trimFactor = 11'h3f6;
      5'h00: trimFactor = 11'h3e8;
      5'h1f: trimFactor = 11'h3c6;
      5'h1e: trimFactor = 11'h3b7;
      5'h1d: trimFactor = 11'h3a0;
      5'h1c: trimFactor = 11'h38d;
      5'h1b: trimFactor = 11'h36a;
      5'h1a: trimFactor = 11'h351;
      5'h19: trimFactor = 11'h32f;
      5'h18: trimFactor = 11'h316;
      5'h17: trimFactor = 11'h2eb;
      5'h16: trimFactor = 11'h2d8;
      5'h15: trimFactor = 11'h2bd;
      5'h14: trimFactor = 11'h2a7;
      5'h13: trimFactor = 11'h282;
      5'h12: trimFactor = 11'h26b;
      5'h11: trimFactor = 11'h24f;
      default: trimFactor = 11'h23a;
    endcase
  endfunction

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      factorPermille <= otcc_pkg::FACTOR_NOMINAL;
    else
      factorPermille <= trimFactor(trimCode);
  end

endmodule
